// ==== common/tenure_pkg.sv ====
/*
 Constants, register layout and carrier types for the low-priority tenure timer.
 Assumes a single ref_clk domain; configuration access is byte wide at printed offsets.
*/
package tenure_pkg;
	localparam logic [7:0] tenure_offset = 8'hbd;
	localparam logic [7:0] hub_cfg_lo_offset = 8'hc6;
	localparam logic [7:0] hub_cfg_hi_offset = 8'hc7;
	localparam logic [7:0] tenure_reset = 8'h10;
	localparam logic [15:0] hub_cfg_reset = 16'h0c01;
	localparam logic [7:0] tenure_wmask = 8'hf8;
	localparam int freq_bit_pos = 12;
	localparam int mem_sel_lsb = 10;
	localparam logic [1:0] mem_sel_166 = 2'h1;
	localparam logic [1:0] mem_sel_133 = 2'h2;
	localparam logic [15:0] hub_cfg_wmask = 16'h0c00;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_low = 2'b01,
		st_high = 2'b10
	} owner_t;

	typedef struct packed {
		logic low_req;
		logic low_is_write;
		logic high_req;
		logic other_req;
	} req_t;

	typedef struct packed {
		logic low_grant;
		logic high_grant;
		logic other_grant;
	} grant_t;
endpackage

// ==== design/tenure_arbiter.sv ====
/*
 Graphics-port arbiter tenure timer with configuration registers.
 Assumes requests are synchronous to ref_clk; port clock and strap pins are not.
*/
`timescale 1ns/1ps
module tenure_arbiter (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic port_clk,
	input wire logic power_good,
	input wire logic front_bus_speed_strap,
	input wire tenure_pkg::req_t req,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output tenure_pkg::grant_t grant,
	output logic [1:0] memory_frequency_select,
	output logic front_bus_frequency_select,
	output logic slice_expired
);
	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic pclk_d;
	logic pgood_d;
	logic [2:0] pin_in;
	assign pin_in = {port_clk, power_good, front_bus_speed_strap};
	// Two stages per pin; only the second stage feeds the logic
	for (genvar b = 0; b < 3; b++) begin : g_sync
		always_ff @(posedge ref_clk) begin
			if (!rst_b) begin
				sync1[b] <= 1'b0;
				sync2[b] <= 1'b0;
			end else begin
				sync1[b] <= pin_in[b];
				sync2[b] <= sync1[b];
			end
		end
	end

	// Edge history; idle low so no false edge after reset
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pclk_d <= 1'b0;
			pgood_d <= 1'b0;
		end else begin
			pclk_d <= sync2[2];
			pgood_d <= sync2[1];
		end
	end
	logic pclk_tick;
	logic pgood_rise;
	assign pclk_tick = sync2[2] & ~pclk_d;
	assign pgood_rise = sync2[1] & ~pgood_d;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] tenure_reg;
	logic [15:0] hub_cfg;
	logic [7:0] next_tenure_reg;
	logic [15:0] next_hub_cfg;
	logic [7:0] next_rdata;
	always_comb begin
		next_tenure_reg = tenure_reg;
		next_hub_cfg = hub_cfg;
		if (cfg_wr) begin
			if (cfg_addr == tenure_pkg::tenure_offset) begin
				next_tenure_reg = cfg_wdata & tenure_pkg::tenure_wmask;
			end else if (cfg_addr == tenure_pkg::hub_cfg_hi_offset) begin
				// Only memory select is writable; the output follows on the same edge as the register
				next_hub_cfg[15:8] = (hub_cfg[15:8] & ~tenure_pkg::hub_cfg_wmask[15:8])
					| (cfg_wdata & tenure_pkg::hub_cfg_wmask[15:8]);
			end
		end
		if (pgood_rise) begin
			next_hub_cfg[tenure_pkg::freq_bit_pos] = sync2[0];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Holds between reads; unmapped offsets read zero
	always_comb begin
		next_rdata = cfg_rdata;
		if (cfg_rd) begin
			if (cfg_addr == tenure_pkg::tenure_offset) begin
				next_rdata = tenure_reg;
			end else if (cfg_addr == tenure_pkg::hub_cfg_lo_offset) begin
				next_rdata = hub_cfg[7:0];
			end else if (cfg_addr == tenure_pkg::hub_cfg_hi_offset) begin
				next_rdata = hub_cfg[15:8];
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Arbitration and tenure count
	// ----------------------------------------
	tenure_pkg::owner_t owner;
	tenure_pkg::owner_t next_owner;
	logic [7:0] count;
	logic [7:0] next_count;
	logic last_write;
	logic next_last_write;
	tenure_pkg::grant_t next_grant;
	logic next_expired;
	always_comb begin
		next_owner = owner;
		next_count = count;
		next_last_write = last_write;
		next_expired = slice_expired;
		case (owner)
			tenure_pkg::st_idle: begin
				if (req.high_req) begin
					next_owner = tenure_pkg::st_high;
				end else if (req.low_req) begin
					next_owner = tenure_pkg::st_low;
					next_count = tenure_reg;
					next_last_write = req.low_is_write;
					next_expired = (tenure_reg == 8'h00);
				end
			end
			tenure_pkg::st_low: begin
				if (pclk_tick && count != 8'h00) begin
					next_count = count - 8'h01;
					if (count == 8'h01) begin
						next_expired = 1'b1;
					end
				end
				if (req.high_req) begin
					next_owner = tenure_pkg::st_high;
				// Type change ends the state; next entry reloads the count
				end else if (!req.low_req || req.low_is_write != last_write) begin
					next_owner = tenure_pkg::st_idle;
				end else if (slice_expired && req.other_req) begin
					next_owner = tenure_pkg::st_idle;
				end
			end
			tenure_pkg::st_high: begin
				if (!req.high_req) begin
					next_owner = tenure_pkg::st_idle;
				end
			end
			default: begin
				next_owner = tenure_pkg::st_idle;
			end
		endcase
		if (next_owner != tenure_pkg::st_low) begin
			next_expired = 1'b0;
		end
		next_grant.high_grant = (next_owner == tenure_pkg::st_high);
		next_grant.low_grant = (next_owner == tenure_pkg::st_low);
		// Other agents only own the bus while nobody else does
		next_grant.other_grant = (next_owner == tenure_pkg::st_idle) && req.other_req && !req.high_req;
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Output copies track the next value so they match the register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tenure_reg <= tenure_pkg::tenure_reset;
			hub_cfg <= tenure_pkg::hub_cfg_reset;
			memory_frequency_select <= tenure_pkg::hub_cfg_reset[tenure_pkg::mem_sel_lsb +: 2];
			front_bus_frequency_select <= tenure_pkg::hub_cfg_reset[tenure_pkg::freq_bit_pos];
		end else begin
			tenure_reg <= next_tenure_reg;
			hub_cfg <= next_hub_cfg;
			memory_frequency_select <= next_hub_cfg[tenure_pkg::mem_sel_lsb +: 2];
			front_bus_frequency_select <= next_hub_cfg[tenure_pkg::freq_bit_pos];
		end
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cfg_rdata <= 8'h00;
		end else begin
			cfg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Arbiter state
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			owner <= tenure_pkg::st_idle;
			count <= 8'h00;
			last_write <= 1'b0;
			grant <= '0;
			slice_expired <= 1'b0;
		end else begin
			owner <= next_owner;
			count <= next_count;
			last_write <= next_last_write;
			grant <= next_grant;
			slice_expired <= next_expired;
		end
	end
endmodule

// ==== dv/agp_master.sv ====
/* Far-side graphics master clock source.
 Assumes the bench drives the requests itself. */
`timescale 1ns/1ps
module agp_master (
	output logic port_clk
);
	// Port clock runs free, unrelated to ref_clk
	initial port_clk = 1'b0;
	always #160 port_clk = ~port_clk;
endmodule

// ==== dv/tenure_checker.sv ====
/* Port assertions for tenure_arbiter.
 Assumes a bind onto the top module. */
`timescale 1ns/1ps
module tenure_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic power_good,
	input wire tenure_pkg::req_t req,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_rdata,
	input wire tenure_pkg::grant_t grant,
	input wire logic [1:0] memory_frequency_select,
	input wire logic front_bus_frequency_select,
	input wire logic slice_expired
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_hi; req.high_req |=> grant.high_grant; endproperty
	a_hi: assert property (p_hi) else $error("high late");
	property p_hold; grant.low_grant && !slice_expired && req.low_req && !req.high_req
		&& $stable(req.low_is_write) |=> grant.low_grant; endproperty
	a_hold: assert property (p_hold) else $error("slice cut");
	property p_yield; grant.low_grant && slice_expired && req.other_req && !req.high_req |=> !grant.low_grant;
	endproperty
	a_yield: assert property (p_yield) else $error("no yield");
	property p_one; $onehot0(grant); endproperty
	a_one: assert property (p_one) else $error("two grants");
	property p_res; cfg_rd && cfg_addr == 8'hbd |=> cfg_rdata[2:0] == 3'h0; endproperty
	a_res: assert property (p_res) else $error("reserved set");
	property p_lo; cfg_rd && cfg_addr == 8'hc6 |=> cfg_rdata == 8'h01; endproperty
	a_lo: assert property (p_lo) else $error("low byte");
	property p_fb; $changed(front_bus_frequency_select) |-> $past(power_good); endproperty
	a_fb: assert property (p_fb) else $error("strap moved");
	property p_mem; $changed(memory_frequency_select) |-> $past(cfg_wr) || $past(cfg_wr, 2); endproperty
	a_mem: assert property (p_mem) else $error("mem moved");
	cover property (grant.high_grant);
	cover property (grant.low_grant && slice_expired);
	cover property (grant.other_grant);
endmodule
bind tenure_arbiter tenure_checker i_chk (.*);

// ==== dv/tb_agp_low_priority_tenure_timer.sv ====
/* Self-checking bench for tenure_arbiter.
 Assumes agp_master supplies port_clk. */
`timescale 1ns/1ps
module tb_agp_low_priority_tenure_timer;
	logic ref_clk = 0, rst_b = 0, power_good = 0, front_bus_speed_strap = 0, cfg_wr = 0, cfg_rd = 0;
	logic port_clk, front_bus_frequency_select, slice_expired, s;
	logic [7:0] cfg_addr = 0, cfg_wdata = 0, cfg_rdata, v, e;
	logic [7:0] ra [4] = '{8'hbd, 8'hc6, 8'hc7, 8'hbe};
	logic [7:0] re [4] = '{8'h10, 8'h01, 8'h0c, 8'h00};
	logic [1:0] memory_frequency_select;
	tenure_pkg::req_t req = '0;
	tenure_pkg::grant_t grant;
	int n_fail = 0, n_tests = 0, n;
	always #20 ref_clk = ~ref_clk;
	tenure_arbiter i_dut (.*);
	agp_master i_agp (.port_clk(port_clk));
	task automatic finish_test;
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] a, input logic [7:0] b);
		n_tests++;
		if (a !== b) begin
			n_fail++;
			$display("wrong value t=%0t got %h exp %h", $time, a, b);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cfg_wr <= w;
		cfg_rd <= !w;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 0;
		cfg_rd <= 0;
		@(negedge ref_clk);
	endtask
	initial begin
		void'($urandom(55635));
		repeat (3) @(posedge ref_clk);
		rst_b <= 1;
		for (int i = 0; i < 4; i++) begin
			acc(0, ra[i], 0);
			cmp(cfg_rdata, re[i]);
		end
		s = $urandom;
		front_bus_speed_strap <= s;
		@(posedge ref_clk) power_good <= 1;
		repeat (8) @(posedge ref_clk);
		cmp(front_bus_frequency_select, s);
		v = $urandom;
		acc(1, 8'hc7, v);
		acc(0, 8'hc7, 0);
		cmp(cfg_rdata, {3'h0, s, v[3:2], 2'h0});
		cmp(memory_frequency_select, v[3:2]);
		// Zero, boundary and random slice lengths
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'h0f : 8'(($urandom % 3 + 1) * 8);
			e = v & 8'hf8;
			acc(1, 8'hbd, v);
			@(posedge ref_clk) req <= {1'b1, i[0], 2'b01};
			n = 0;
			while (slice_expired !== 1'b1 && n < 400) begin
				@(negedge ref_clk);
				n++;
			end
			if (n == 400) begin
				n_fail++;
				finish_test;
			end
			cmp(8'(n + 16 >= e * 8 && n <= e * 8 + 16), 1);
			@(negedge ref_clk);
			cmp(grant.low_grant, 0);
			req <= '0;
			repeat (3) @(posedge ref_clk);
		end
		acc(1, 8'hbd, 8'hf8);
		@(posedge ref_clk) req <= 4'b1000;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		cmp(grant, 3'b100);
		@(posedge ref_clk) req.high_req <= 1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmp(grant, 3'b010);
		finish_test;
	end
endmodule
